/* inc/ltb_pkg.sv */
package ltb_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ = 50_000_000; // 20 ns period
    localparam int unsigned TICK_US = 1000; // delay settings count in 1 ms
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US; // cycles per tick
    localparam int unsigned TW = 16; // width of a delay setting
    localparam int unsigned SW = 8; // width of a speed value
    // controller register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] T4_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    // control register fields
    localparam int unsigned CTRL_UP = 0;
    localparam int unsigned CTRL_DOWN = 1;
    localparam int unsigned CTRL_EN_A = 2;
    localparam int unsigned CTRL_EN_B = 3;
    localparam int unsigned CTRL_SEL_A = 4;
    localparam int unsigned CTRL_SEL_B = 5;
    localparam int unsigned CTRL_HIGH = 6;
    localparam int unsigned CTRL_W = 7;
    // status register fields
    localparam int unsigned STAT_BRAKE = 0;
    localparam int unsigned STAT_CONT = 1;
    localparam int unsigned STAT_LED_UP = 2;
    localparam int unsigned STAT_LED_DN = 3;
    localparam int unsigned STAT_ZERO = 4;
    localparam int unsigned STAT_MAIN = 5;
    localparam int unsigned STAT_SPEED = 8;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [TW-1:0] T4_RST = 16'h0064;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // travel sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN, ST_STOP} ltb_state_e;
endpackage : ltb_pkg

/* inc/ltb_if.sv */
`timescale 1ns/1ns
interface ltb_if;
    logic travel_up_cmd; // run upward
    logic travel_down_cmd; // run downward
    logic safety_enable_a; // first enable
    logic safety_enable_b; // second enable
    logic speed_select_bit_a; // creep code bit a
    logic speed_select_bit_b; // creep code bit b
    logic high_speed_select; // high speed request
    logic brake_ctrl; // high opens the brake
    logic contactor_drive_out; // main contactor drive
    logic run_up_led; // up run indicator
    logic run_down_led; // down run indicator
    logic zero_speed; // cabin stands still
    logic [ltb_pkg::SW-1:0] speed_fb; // present speed
    modport dev(input travel_up_cmd, input travel_down_cmd, input safety_enable_a,
        input safety_enable_b, input speed_select_bit_a, input speed_select_bit_b,
        input high_speed_select, output brake_ctrl, output contactor_drive_out,
        output run_up_led, output run_down_led, output zero_speed, output speed_fb);
    modport ctl(output travel_up_cmd, output travel_down_cmd, output safety_enable_a,
        output safety_enable_b, output speed_select_bit_a, output speed_select_bit_b,
        output high_speed_select, input brake_ctrl, input contactor_drive_out,
        input run_up_led, input run_down_led, input zero_speed, input speed_fb);
endinterface : ltb_if

/* rtl/ltb_drive.sv */
// Function
// - direction plus both enables starts both timers
// - speed selections accepted while delays count
// - brake output opens when release delay ends
// - speed applied only after start delay
// - dropping high speed decelerates to creep
// - dropping creep decelerates; zero starts apply delay
// - brake output closes when apply delay ends
// - contactors open only after brake closed
// - start delay from its own setting
// - brake release delay from separate setting
// - brake apply delay from third setting
// - controller times enable-to-contactor open delay
// - run indicator lit while run command present
`timescale 1ns/1ns
module ltb_drive #(
    parameter int unsigned TICK_CYC = ltb_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    ltb_if.dev link,
    input wire logic [ltb_pkg::TW-1:0] start_move_time_setting,
    input wire logic [ltb_pkg::TW-1:0] brake_release_time_setting,
    input wire logic [ltb_pkg::TW-1:0] brake_apply_time_setting,
    input wire logic [ltb_pkg::SW-1:0] high_speed_setpoint,
    input wire logic [ltb_pkg::SW-1:0] creep_setpoint_a,
    input wire logic [ltb_pkg::SW-1:0] creep_setpoint_b,
    input wire logic [ltb_pkg::SW-1:0] creep_setpoint_c,
    input wire logic [ltb_pkg::SW-1:0] accel_step,
    output logic travel_active
);
    localparam int unsigned PW = $clog2(TICK_CYC + 1); // prescaler width
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYC - 1);

    ltb_pkg::ltb_state_e state_q, state_d; // sequencer state
    logic [PW-1:0] pre_q, pre_d; // tick prescaler
    logic [ltb_pkg::TW-1:0] t_move_q, t_move_d; // start_move_delay count
    logic [ltb_pkg::TW-1:0] t_rel_q, t_rel_d; // brake_release_delay count
    logic [ltb_pkg::TW-1:0] t_app_q, t_app_d; // brake_apply_delay count
    logic [ltb_pkg::SW-1:0] speed_q, speed_d; // present speed
    logic brake_q, brake_d; // brake open request
    logic cont_q, cont_d; // contactor drive
    logic led_up_q, led_up_d; // up indicator
    logic led_dn_q, led_dn_d; // down indicator
    logic tick; // one ms strobe
    logic cmd_ok; // valid run command
    logic move_done; // start delay over
    logic rel_done; // release delay over
    logic app_done; // apply delay over
    logic [2:0] sel_code; // combined speed selection
    logic [ltb_pkg::SW-1:0] target; // selected set point

    // step a value toward a target by at most one step
    function automatic logic [ltb_pkg::SW-1:0] ramp(
        input logic [ltb_pkg::SW-1:0] cur,
        input logic [ltb_pkg::SW-1:0] tgt,
        input logic [ltb_pkg::SW-1:0] step
    );
        logic [ltb_pkg::SW-1:0] gap;
        gap = (cur < tgt) ? tgt - cur : cur - tgt;
        if (gap <= step) begin
            ramp = tgt;
        end else if (cur < tgt) begin
            ramp = cur + step;
        end else begin
            ramp = cur - step;
        end
    endfunction : ramp

    // saturating delay count on each tick
    function automatic logic [ltb_pkg::TW-1:0] count_up(
        input logic [ltb_pkg::TW-1:0] cnt,
        input logic [ltb_pkg::TW-1:0] lim,
        input logic stb
    );
        count_up = (stb && cnt < lim) ? cnt + 1'b1 : cnt;
    endfunction : count_up

    // command qualification and set point decode
    always_comb begin
        cmd_ok = (link.travel_up_cmd ^ link.travel_down_cmd)
            && link.safety_enable_a && link.safety_enable_b;
        sel_code = {link.high_speed_select, link.speed_select_bit_b,
            link.speed_select_bit_a};
        unique case (sel_code)
            3'h0: target = '0; // nothing selected: stop
            3'h1: target = creep_setpoint_a;
            3'h2: target = creep_setpoint_b;
            3'h3: target = creep_setpoint_c;
            default: target = high_speed_setpoint; // high speed wins
        endcase
        tick = (pre_q == TICK_LAST);
        move_done = (t_move_q >= start_move_time_setting);
        rel_done = (t_rel_q >= brake_release_time_setting);
        app_done = (t_app_q >= brake_apply_time_setting);
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        pre_d = tick ? '0 : pre_q + 1'b1;
        t_move_d = count_up(t_move_q, start_move_time_setting, tick);
        t_rel_d = count_up(t_rel_q, brake_release_time_setting, tick);
        t_app_d = t_app_q;
        speed_d = speed_q;
        brake_d = brake_q;
        unique case (state_q)
            ltb_pkg::ST_IDLE: begin
                pre_d = '0;
                speed_d = '0;
                brake_d = 1'b0;
                if (cmd_ok) begin
                    // both delays start together from zero
                    state_d = ltb_pkg::ST_START;
                    t_move_d = '0;
                    t_rel_d = '0;
                end
            end
            ltb_pkg::ST_START: begin
                // selections may change freely, only applied later
                if (rel_done) begin
                    brake_d = 1'b1;
                end
                if (move_done) begin
                    state_d = ltb_pkg::ST_RUN;
                end
            end
            ltb_pkg::ST_RUN: begin
                if (rel_done) begin
                    brake_d = 1'b1;
                end
                if (tick) begin
                    speed_d = ramp(speed_q, target, accel_step);
                end
                if (target == '0 && speed_q == '0) begin
                    state_d = ltb_pkg::ST_STOP;
                    t_app_d = '0;
                end
            end
            ltb_pkg::ST_STOP: begin
                speed_d = '0;
                t_app_d = count_up(t_app_q, brake_apply_time_setting, tick);
                if (app_done) begin
                    brake_d = 1'b0;
                    state_d = ltb_pkg::ST_IDLE;
                end
            end
        endcase
        if (state_q != ltb_pkg::ST_IDLE && !cmd_ok) begin
            // abort: drop drive and brake at once
            state_d = ltb_pkg::ST_IDLE;
            speed_d = '0;
            brake_d = 1'b0;
        end
    end

    // outputs: contactor held one cycle past the brake
    always_comb begin
        cont_d = (state_d != ltb_pkg::ST_IDLE) || brake_q;
        led_up_d = link.travel_up_cmd;
        led_dn_d = link.travel_down_cmd;
    end

    // state registers, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ltb_pkg::ST_IDLE;
            pre_q <= '0;
            t_move_q <= '0;
            t_rel_q <= '0;
            t_app_q <= '0;
            speed_q <= '0;
            brake_q <= 1'b0;
            cont_q <= 1'b0;
            led_up_q <= 1'b0;
            led_dn_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            pre_q <= pre_d;
            t_move_q <= t_move_d;
            t_rel_q <= t_rel_d;
            t_app_q <= t_app_d;
            speed_q <= speed_d;
            brake_q <= brake_d;
            cont_q <= cont_d;
            led_up_q <= led_up_d;
            led_dn_q <= led_dn_d;
        end
    end

    // drive the link from flip-flops
    assign link.brake_ctrl = brake_q;
    assign link.contactor_drive_out = cont_q;
    assign link.run_up_led = led_up_q;
    assign link.run_down_led = led_dn_q;
    assign link.speed_fb = speed_q;
    assign link.zero_speed = (speed_q == '0);
    assign travel_active = (state_q != ltb_pkg::ST_IDLE);
endmodule : ltb_drive

/* rtl/ltb_ctrl.sv */
`timescale 1ns/1ns
module ltb_ctrl #(
    parameter int unsigned TICK_CYC = ltb_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    ltb_if.ctl link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic main_contactor_out
);
    localparam int unsigned PW = $clog2(TICK_CYC + 1); // prescaler width
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYC - 1);

    logic [ltb_pkg::CTRL_W-1:0] ctrl_q, ctrl_d; // link command bits
    logic [ltb_pkg::TW-1:0] t4_q, t4_d; // contactor_open_delay in ms
    logic aw_got_q, aw_got_d; // write address held
    logic w_got_q, w_got_d; // write data held
    logic [3:0] awa_q, awa_d; // held write address
    logic [31:0] wd_q, wd_d; // held write data
    logic [3:0] ws_q, ws_d; // held strobes
    logic bv_q, bv_d; // write response pending
    logic [1:0] br_q, br_d; // write response code
    logic rv_q, rv_d; // read data pending
    logic [31:0] rd_q, rd_d; // read data
    logic [1:0] rr_q, rr_d; // read response code
    logic [PW-1:0] pre_q, pre_d; // tick prescaler
    logic [ltb_pkg::TW-1:0] cnt_q, cnt_d; // contactor open count
    logic main_q, main_d; // main contactor request
    logic [31:0] status; // live status word
    logic en_on; // both enables driven

    // status word from link inputs and main_q
    always_comb begin
        status = '0;
        status[ltb_pkg::STAT_BRAKE] = link.brake_ctrl;
        status[ltb_pkg::STAT_CONT] = link.contactor_drive_out;
        status[ltb_pkg::STAT_LED_UP] = link.run_up_led;
        status[ltb_pkg::STAT_LED_DN] = link.run_down_led;
        status[ltb_pkg::STAT_ZERO] = link.zero_speed;
        status[ltb_pkg::STAT_MAIN] = main_q;
        status[ltb_pkg::STAT_SPEED +: ltb_pkg::SW] = link.speed_fb;
        en_on = ctrl_q[ltb_pkg::CTRL_EN_A] && ctrl_q[ltb_pkg::CTRL_EN_B];
    end

    // bus slave next state
    always_comb begin
        ctrl_d = ctrl_q;
        t4_d = t4_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        // capture address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        // commit once both halves are held
        if (aw_got_q && w_got_q && !bv_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bv_d = 1'b1;
            br_d = ltb_pkg::RESP_OK;
            unique case (awa_q[3:2])
                ltb_pkg::CTRL_OFS[3:2]: begin
                    if (ws_q[0]) begin
                        ctrl_d = wd_q[ltb_pkg::CTRL_W-1:0];
                    end
                end
                ltb_pkg::T4_OFS[3:2]: begin
                    if (ws_q[0]) begin
                        t4_d[7:0] = wd_q[7:0];
                    end
                    if (ws_q[1]) begin
                        t4_d[15:8] = wd_q[15:8];
                    end
                end
                ltb_pkg::STAT_OFS[3:2]: br_d = ltb_pkg::RESP_OK; // read only
                default: br_d = ltb_pkg::RESP_ERR; // unmapped
            endcase
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        // reads answer one cycle after address
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = ltb_pkg::RESP_OK;
            unique case (s_axi_araddr[3:2])
                ltb_pkg::CTRL_OFS[3:2]: rd_d = {25'h0000000, ctrl_q};
                ltb_pkg::T4_OFS[3:2]: rd_d = {16'h0000, t4_q};
                ltb_pkg::STAT_OFS[3:2]: rd_d = status;
                default: begin
                    rd_d = '0;
                    rr_d = ltb_pkg::RESP_ERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    // contactor timing after enables drop
    always_comb begin
        pre_d = (pre_q == TICK_LAST) ? '0 : pre_q + 1'b1;
        cnt_d = cnt_q;
        main_d = main_q;
        if (en_on) begin
            pre_d = '0;
            cnt_d = '0;
            main_d = 1'b1;
        end else if (main_q) begin
            if (cnt_q >= t4_q) begin
                main_d = 1'b0;
            end else if (pre_q == TICK_LAST) begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // registers, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= ltb_pkg::CTRL_RST;
            t4_q <= ltb_pkg::T4_RST;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            bv_q <= 1'b0;
            br_q <= ltb_pkg::RESP_OK;
            rv_q <= 1'b0;
            rd_q <= '0;
            rr_q <= ltb_pkg::RESP_OK;
            pre_q <= '0;
            cnt_q <= '0;
            main_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            t4_q <= t4_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            main_q <= main_d;
        end
    end

    // bus handshakes and link drive
    assign s_axi_awready = ce && !aw_got_q && !bv_q;
    assign s_axi_wready = ce && !w_got_q && !bv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = ce && !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign link.travel_up_cmd = ctrl_q[ltb_pkg::CTRL_UP];
    assign link.travel_down_cmd = ctrl_q[ltb_pkg::CTRL_DOWN];
    assign link.safety_enable_a = ctrl_q[ltb_pkg::CTRL_EN_A];
    assign link.safety_enable_b = ctrl_q[ltb_pkg::CTRL_EN_B];
    assign link.speed_select_bit_a = ctrl_q[ltb_pkg::CTRL_SEL_A];
    assign link.speed_select_bit_b = ctrl_q[ltb_pkg::CTRL_SEL_B];
    assign link.high_speed_select = ctrl_q[ltb_pkg::CTRL_HIGH];
    assign main_contactor_out = main_q;
endmodule : ltb_ctrl

/* sim/ltb_link_sva.sv */
`timescale 1ns/1ns
// watches the link between controller end and drive end
module ltb_link_sva #(
    parameter int unsigned TICK_CYC = 4,
    parameter int unsigned T1 = 3,
    parameter int unsigned T2 = 1,
    parameter int unsigned T3 = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic travel_up_cmd,
    input wire logic travel_down_cmd,
    input wire logic safety_enable_a,
    input wire logic safety_enable_b,
    input wire logic speed_select_bit_a,
    input wire logic speed_select_bit_b,
    input wire logic high_speed_select,
    input wire logic brake_ctrl,
    input wire logic contactor_drive_out,
    input wire logic run_up_led,
    input wire logic run_down_led,
    input wire logic zero_speed,
    input wire logic [ltb_pkg::SW-1:0] speed_fb
);
    localparam int REL = T2 * TICK_CYC; // release delay in cycles
    localparam int MOV = T1 * TICK_CYC; // start delay in cycles
    localparam int APP = T3 * TICK_CYC; // apply delay in cycles
    localparam int TK = TICK_CYC; // one tick of slack
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cmd_ok; // one direction plus both enables
    logic no_sel; // every speed selection off
    logic brake_q; // brake output one cycle back
    logic [15:0] run_cnt_q, run_cnt_d; // cycles since contactor closed
    logic [15:0] zero_cnt_q, zero_cnt_d; // cycles at standstill
    assign cmd_ok = (travel_up_cmd ^ travel_down_cmd) & safety_enable_a & safety_enable_b;
    assign no_sel = !high_speed_select && !speed_select_bit_a && !speed_select_bit_b;
    // next counts; restart on a brake fall so a back-to-back travel is timed afresh
    always_comb begin
        run_cnt_d = (!contactor_drive_out || (brake_q && !brake_ctrl)) ? 16'h0000 : run_cnt_q + 16'h0001;
        zero_cnt_d = zero_speed ? zero_cnt_q + 16'h0001 : 16'h0000;
    end
    // register the helper counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_cnt_q <= 16'h0000;
            zero_cnt_q <= 16'h0000;
            brake_q <= 1'b0;
        end else begin
            run_cnt_q <= run_cnt_d;
            zero_cnt_q <= zero_cnt_d;
            brake_q <= brake_ctrl;
        end
    end
    led_up_a: assert property (run_up_led == $past(travel_up_cmd))
        else $error("up indicator not following command");
    led_down_a: assert property (run_down_led == $past(travel_down_cmd))
        else $error("down indicator not following command");
    abort_brake_a: assert property (!cmd_ok |=> !brake_ctrl)
        else $error("brake open without run command");
    abort_speed_a: assert property (!cmd_ok |=> speed_fb == 8'h00)
        else $error("speed held without run command");
    cont_order_a: assert property ($fell(contactor_drive_out) |-> !brake_ctrl && !$past(brake_ctrl))
        else $error("contactor opened before brake closed");
    no_sel_a: assert property (no_sel [*2] |=> speed_fb <= $past(speed_fb))
        else $error("speed rose with no selection");
    release_time_a: assert property ($rose(brake_ctrl) |-> run_cnt_q >= REL - 3 && run_cnt_q <= REL + 4)
        else $error("brake release delay wrong");
    motion_time_a: assert property ($rose(speed_fb != 8'h00) |-> run_cnt_q >= MOV - 3 && run_cnt_q <= MOV + TK + 4)
        else $error("motion began at wrong time");
    apply_time_a: assert property ($fell(brake_ctrl) && $past(cmd_ok) |-> zero_cnt_q >= APP - TK - 2 && zero_cnt_q <= APP + TK + 4)
        else $error("brake apply delay wrong");
    release_c: cover property ($rose(brake_ctrl));
    apply_c: cover property ($fell(brake_ctrl) && $past(cmd_ok));
    abort_c: cover property ($fell(cmd_ok) && brake_ctrl);
endmodule : ltb_link_sva

/* sim/lift_travel_brake_sequencer_tb.sv */
`timescale 1ns/1ns
module lift_travel_brake_sequencer_tb;
    localparam int unsigned TK = 4; // short tick for simulation
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1; // clock, reset, enable
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF; // bus address and strobes
    logic [31:0] wdata = 32'h0, rdata; // bus data
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1; // master side
    logic awready, wready, arready, bvalid, rvalid, main_cont, active; // slave side and status
    logic [1:0] bresp, rresp; // response codes
    logic [15:0] t1 = 16'h0003, t2 = 16'h0001, t3 = 16'h0002; // delay settings in ticks
    logic [7:0] sp_hi = 8'h40, sp_a = 8'h10, sp_b = 8'h18, sp_c = 8'h20, step = 8'h08; // speeds
    int miscompares = 0, comparisons = 0; // tallies
    int k; // creep code loop
    // free running 50 MHz clock
    always #10 clk = ~clk;
    ltb_if link();
    ltb_drive #(.TICK_CYC(TK)) u_ltb_drive (.clk(clk), .rst_n(rst_n), .ce(ce), .link(link),
        .start_move_time_setting(t1), .brake_release_time_setting(t2), .brake_apply_time_setting(t3),
        .high_speed_setpoint(sp_hi), .creep_setpoint_a(sp_a), .creep_setpoint_b(sp_b),
        .creep_setpoint_c(sp_c), .accel_step(step), .travel_active(active));
    ltb_ctrl #(.TICK_CYC(TK)) u_ltb_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce), .link(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .main_contactor_out(main_cont));
    ltb_link_sva #(.TICK_CYC(TK), .T1(3), .T2(1), .T3(2)) u_ltb_link_sva (.clk(clk), .rst_n(rst_n),
        .travel_up_cmd(link.travel_up_cmd), .travel_down_cmd(link.travel_down_cmd),
        .safety_enable_a(link.safety_enable_a), .safety_enable_b(link.safety_enable_b),
        .speed_select_bit_a(link.speed_select_bit_a), .speed_select_bit_b(link.speed_select_bit_b),
        .high_speed_select(link.high_speed_select), .brake_ctrl(link.brake_ctrl),
        .contactor_drive_out(link.contactor_drive_out), .run_up_led(link.run_up_led),
        .run_down_led(link.run_down_led), .zero_speed(link.zero_speed), .speed_fb(link.speed_fb));
    // one comparison, counted
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // verdict and end of run
    task close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // bus write; waits for the response
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta, tw, got;
        got = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!got) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            if (bvalid) chk("write response", {30'h0, er}, {30'h0, bresp});
            got = bvalid;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        chk("write taken", 32'h0, {31'h0, awvalid | wvalid});
    endtask : wr
    // bus read, checks data and response
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        bit ta, got;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!got) begin
            @(negedge clk);
            ta = arvalid && arready;
            if (rvalid) chk("read data", e, rdata);
            if (rvalid) chk("read response", {30'h0, er}, {30'h0, rresp});
            got = rvalid;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        chk("read taken", 32'h0, {31'h0, arvalid});
    endtask : rd
    // selects one observed output
    function automatic logic [31:0] pick(input int s);
        case (s)
            0: return {24'h0, link.speed_fb};
            1: return {31'h0, link.brake_ctrl};
            2: return {31'h0, main_cont};
            3: return {31'h0, link.run_up_led};
            4: return {31'h0, link.run_down_led};
            6: return {31'h0, active};
            default: return {31'h0, link.contactor_drive_out};
        endcase
    endfunction : pick
    // bounded wait for an output value, then compare
    task waitv(input int s, input logic [31:0] e, input string nm);
        int n;
        @(negedge clk);
        for (n = 0; n < 800 && pick(s) !== e; n++) @(negedge clk);
        chk(nm, e, pick(s));
        @(posedge clk);
    endtask : waitv
    // compare an output at the next settled point
    task see(input int s, input logic [31:0] e, input string nm);
        @(negedge clk);
        chk(nm, e, pick(s));
        @(posedge clk);
    endtask : see
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(ltb_pkg::CTRL_OFS, 32'h0, ltb_pkg::RESP_OK);
        rd(ltb_pkg::T4_OFS, 32'h64, ltb_pkg::RESP_OK);
        rd(ltb_pkg::STAT_OFS, 32'h10, ltb_pkg::RESP_OK);
        rd(4'hC, 32'h0, ltb_pkg::RESP_ERR);
        wr(4'hC, 32'hFFFFFFFF, ltb_pkg::RESP_ERR);
        wr(ltb_pkg::T4_OFS, 32'h3, ltb_pkg::RESP_OK);
        wr(ltb_pkg::CTRL_OFS, 32'h5D, ltb_pkg::RESP_OK);
        waitv(1, 32'h1, "brake open");
        see(0, 32'h0, "speed at brake open");
        see(5, 32'h1, "contactor closed");
        see(6, 32'h1, "travel active");
        waitv(0, 32'h40, "high speed");
        see(3, 32'h1, "up indicator");
        for (k = 1; k < 4; k++) begin
            wr(ltb_pkg::CTRL_OFS, 32'h0D | (k << 4), ltb_pkg::RESP_OK);
            waitv(0, k == 1 ? sp_a : (k == 2 ? sp_b : sp_c), "creep speed");
        end
        wr(ltb_pkg::CTRL_OFS, 32'h0D, ltb_pkg::RESP_OK);
        waitv(0, 32'h0, "stopped");
        see(1, 32'h1, "brake held at zero");
        waitv(1, 32'h0, "brake applied");
        wr(ltb_pkg::CTRL_OFS, 32'h0, ltb_pkg::RESP_OK);
        see(2, 32'h1, "main contactor held");
        waitv(2, 32'h0, "main contactor open");
        wr(ltb_pkg::CTRL_OFS, 32'h4E, ltb_pkg::RESP_OK);
        waitv(0, 32'h08, "moving down");
        see(4, 32'h1, "down indicator");
        wr(ltb_pkg::CTRL_OFS, 32'h46, ltb_pkg::RESP_OK);
        see(1, 32'h0, "brake after abort");
        see(0, 32'h0, "speed after abort");
        wr(ltb_pkg::CTRL_OFS, 32'h4F, ltb_pkg::RESP_OK);
        repeat (20) @(posedge clk);
        see(5, 32'h0, "no travel on both directions");
        rd(ltb_pkg::STAT_OFS, 32'h3C, ltb_pkg::RESP_OK);
        wr(ltb_pkg::CTRL_OFS, 32'h0, ltb_pkg::RESP_OK);
        close_out;
    end
    // watchdog against a hang
    initial begin
        #200000;
        miscompares++;
        close_out;
    end
endmodule : lift_travel_brake_sequencer_tb
